// ### sim/ltv_partner.sv
// far side model: product data store and extended register responder
`timescale 1ns/100ps
module ltv_partner (
    input wire logic clock_i,
    input wire logic ee_req_i,
    input wire logic ee_we_i,
    input wire logic [8:0] ee_addr_i,
    input wire logic [31:0] ee_wdata_i,
    output logic ee_ack_o,
    output logic [31:0] ee_rdata_o,
    input wire logic ext_rd_i,
    input wire logic ext_wr_i,
    input wire logic [11:0] ext_addr_i,
    input wire logic [3:0] ext_be_i,
    input wire logic [31:0] ext_wdata_i,
    output logic ext_ack_o,
    output logic [31:0] ext_rdata_o
);
    logic [7:0] ee_mem [0:511];
    logic [31:0] ext_mem [0:1023];
    logic [8:0] ea;
    logic [9:0] xa;
    // ==========================================================
    // byte store, low byte of a word at the given address
    initial begin
        for (int i = 0; i < 512; i++) ee_mem[i] = 8'(i) ^ 8'h3C;
        for (int i = 0; i < 1024; i++) ext_mem[i] = 32'h0;
        ee_ack_o = 1'b0;
        ee_rdata_o = 32'hFFFF_FFFF;
        forever begin
            @(posedge clock_i);
            if (ee_req_i === 1'b1) begin
                ea = ee_addr_i;
                repeat ($urandom_range(3, 0)) @(posedge clock_i);
                for (int b = 0; b < 4; b++) begin
                    if (ee_we_i) ee_mem[ea + 9'(b)] = ee_wdata_i[8*b+:8];
                    ee_rdata_o[8*b+:8] <= ee_mem[ea + 9'(b)];
                end
                ee_ack_o <= 1'b1;
                @(posedge clock_i);
                ee_ack_o <= 1'b0;
                ee_rdata_o <= ~ee_rdata_o;
            end
        end
    end
    // ==========================================================
    // forwarded register access, byte enables honoured
    initial begin
        ext_ack_o = 1'b0;
        ext_rdata_o = 32'hFFFF_FFFF;
        forever begin
            @(posedge clock_i);
            if (ext_rd_i === 1'b1 || ext_wr_i === 1'b1) begin
                xa = ext_addr_i[11:2];
                for (int b = 0; b < 4; b++) begin
                    if (ext_wr_i && ext_be_i[b])
                        ext_mem[xa][8*b+:8] = ext_wdata_i[8*b+:8];
                end
                repeat ($urandom_range(3, 0)) @(posedge clock_i);
                ext_ack_o <= 1'b1;
                ext_rdata_o <= ext_mem[xa];
                @(posedge clock_i);
                ext_ack_o <= 1'b0;
                ext_rdata_o <= ~ext_mem[xa];
            end
        end
    end
endmodule : ltv_partner

// ### sim/tb_ltv_regs.sv
// self-checking bench for the link tuning and product data registers
`timescale 1ns/100ps
module tb_ltv_regs;
    logic clock_i, rst_i, cfg_rd_i, cfg_wr_i, cfg_ack_o, ee_req_o, ee_we_o;
    logic ee_ack_i, ext_rd_o, ext_wr_o, ext_ack_i;
    logic [11:0] cfg_addr_i, ext_addr_o;
    logic [3:0] cfg_be_i, ext_be_o, be;
    logic [8:0] ee_addr_o;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, ee_wdata_o, ee_rdata_i;
    logic [31:0] ext_wdata_o, ext_rdata_i, tune0_o, timers_o, tune2_o, q, d;
    logic [31:0] shadow [4];
    logic [5:0] p;
    int num_errors = 0;
    int checks_done = 0;
    int k;
    localparam logic [11:0] OFS [4] = '{12'h0CC, 12'h0D0, 12'h0D4, 12'h0E0};
    localparam logic [31:0] RST [4] = '{32'h0400_1060, 32'h0400_0800,
        32'h0099_8254, 32'h0};
    localparam logic [31:0] MSK [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'h00FF_FFFF, 32'h0000_0FFF};
    ltv_regs dut (.clock_i, .rst_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i,
        .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .ee_req_o,
        .ee_we_o, .ee_addr_o, .ee_wdata_o, .ee_ack_i, .ee_rdata_i, .ext_rd_o,
        .ext_wr_o, .ext_addr_o, .ext_be_o, .ext_wdata_o, .ext_ack_i,
        .ext_rdata_i, .tune0_o, .timers_o, .tune2_o);
    ltv_partner partner (.clock_i, .ee_req_i(ee_req_o), .ee_we_i(ee_we_o),
        .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o), .ee_ack_o(ee_ack_i),
        .ee_rdata_o(ee_rdata_i), .ext_rd_i(ext_rd_o), .ext_wr_i(ext_wr_o),
        .ext_addr_i(ext_addr_o), .ext_be_i(ext_be_o),
        .ext_wdata_i(ext_wdata_o), .ext_ack_o(ext_ack_i),
        .ext_rdata_o(ext_rdata_i));
    // ==========================================================
    // expectation helpers
    function automatic logic [31:0] merge(input logic [31:0] o, n,
        input logic [3:0] e, input logic [31:0] m);
        logic [31:0] r;
        for (int b = 0; b < 4; b++) r[8*b+:8] = e[b] ? n[8*b+:8] : o[8*b+:8];
        return r & m;
    endfunction : merge
    function automatic logic [31:0] eew(input logic [5:0] a);
        logic [8:0] s;
        s = 9'h040 + {1'b0, a, 2'b00};
        return {s[7:0] + 8'h3, s[7:0] + 8'h2, s[7:0] + 8'h1, s[7:0]}
            ^ 32'h3C3C_3C3C;
    endfunction : eew
    // ==========================================================
    // bus cycles and comparison
    task automatic chk(input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [3:0] e, input logic [31:0] x);
        int n;
        n = 0;
        cfg_wr_i <= w;
        cfg_rd_i <= !w;
        cfg_addr_i <= a;
        cfg_be_i <= e;
        cfg_wdata_i <= x;
        @(posedge clock_i);
        cfg_wr_i <= 1'b0;
        cfg_rd_i <= 1'b0;
        do begin
            @(posedge clock_i);
            n++;
        end while (cfg_ack_o !== 1'b1 && n < 60);
        if (n >= 60) chk(32'h0, 32'h1);
        q = cfg_rdata_o;
    endtask : acc
    task automatic vpd(input logic op, input logic [5:0] a);
        int n;
        n = 0;
        acc(1'b1, 12'h0D8, 4'hF, {op, 7'h7F, a, 18'h3FFFF});
        do begin
            acc(1'b0, 12'h0D8, 4'hF, 32'h0);
            n++;
        end while (q[31] === op && n < 40);
        chk(q, {~op, 7'h0, a, 18'h0F003});
    endtask : vpd
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // ==========================================================
    // clock, watchdog and test sequence
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
    initial begin
        rst_i = 1'b1;
        {cfg_rd_i, cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = '0;
        k = $urandom(11201);
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, OFS[i], 4'hF, 32'h0);
            chk(q, RST[i]);
            shadow[i] = RST[i];
        end
        acc(1'b0, 12'h0DC, 4'hF, 32'h0);
        chk(q, 32'h0);
        $display("test reset values done");
        acc(1'b1, 12'h0D4, 4'hF, 32'hFFFF_FFFF);
        shadow[2] = 32'h00FF_FFFF;
        repeat (40) begin
            k = $urandom_range(3, 0);
            d = $urandom;
            be = 4'($urandom);
            acc(1'b1, OFS[k], be, d);
            shadow[k] = merge(shadow[k], d, be, MSK[k]);
            k = $urandom_range(3, 0);
            acc(1'b0, OFS[k], 4'hF, 32'h0);
            chk(q, shadow[k]);
        end
        chk(tune0_o, shadow[0]);
        chk(timers_o, shadow[1]);
        chk(tune2_o, shadow[2]);
        $display("test random writes done");
        for (int j = 0; j < 6; j++) begin
            p = (j == 0) ? 6'h00 : (j == 1) ? 6'h3F : 6'($urandom);
            vpd(1'b0, p);
            acc(1'b0, 12'h0DC, 4'hF, 32'h0);
            chk(q, eew(p));
        end
        d = $urandom;
        acc(1'b1, 12'h0DC, 4'hF, d);
        acc(1'b1, 12'h0DC, 4'b0010, ~d);
        d = merge(d, ~d, 4'b0010, 32'hFFFF_FFFF);
        acc(1'b0, 12'h0DC, 4'hF, 32'h0);
        chk(q, d);
        p = 6'($urandom);
        vpd(1'b1, p);
        acc(1'b1, 12'h0DC, 4'hF, 32'h0);
        vpd(1'b0, p);
        acc(1'b0, 12'h0DC, 4'hF, 32'h0);
        chk(q, d);
        $display("test product data done");
        acc(1'b1, 12'h0E0, 4'hF, 32'hFFFF_F104);
        d = $urandom;
        acc(1'b1, 12'h0E4, 4'hF, d);
        acc(1'b1, 12'h0E4, 4'b0101, ~d);
        acc(1'b0, 12'h0E4, 4'hF, 32'h0);
        chk(q, merge(d, ~d, 4'b0101, 32'hFFFF_FFFF));
        acc(1'b1, 12'h0E0, 4'hF, 32'h0000_00CC);
        acc(1'b0, 12'h0E4, 4'hF, 32'h0);
        chk(q, shadow[0]);
        $display("test extended window done");
        conclude();
    end
endmodule : tb_ltv_regs

// ### src/ltv_pkg.sv
// constants for the link tuning and product data configuration registers
package ltv_pkg;
    // ==================================================================
    // register offsets (byte addresses of configuration space)
    localparam logic [11:0] TUNE0_OFS = 12'h0CC;
    localparam logic [11:0] TIMERS_OFS = 12'h0D0;
    localparam logic [11:0] TUNE2_OFS = 12'h0D4;
    localparam logic [11:0] VPD_CAP_OFS = 12'h0D8;
    localparam logic [11:0] VPD_DATA_OFS = 12'h0DC;
    localparam logic [11:0] EXT_IDX_OFS = 12'h0E0;
    localparam logic [11:0] EXT_DATA_OFS = 12'h0E4;
    // ==================================================================
    // reset values
    localparam logic [31:0] TUNE0_RST = 32'h0400_1060;
    localparam logic [31:0] TIMERS_RST = 32'h0400_0800;
    localparam logic [31:0] TUNE2_RST = 32'h0099_8254;
    localparam logic [31:0] VPD_DATA_RST = 32'h0000_0000;
    localparam logic [11:0] EXT_IDX_RST = 12'h000;
    localparam logic [5:0] VPD_ADDR_RST = 6'h00;
    localparam logic VPD_FLAG_RST = 1'b0;
    // ==================================================================
    // writable bit masks
    localparam logic [31:0] TUNE0_WMASK = 32'hFFFF_FFFF;
    localparam logic [31:0] TIMERS_WMASK = 32'hFFFF_FFFF;
    localparam logic [31:0] TUNE2_WMASK = 32'h00FF_FFFF;
    localparam logic [31:0] EXT_IDX_WMASK = 32'h0000_0FFF;
    // ==================================================================
    // capability header and field positions
    localparam logic [7:0] VPD_CAP_ID = 8'h03;
    localparam logic [7:0] VPD_NEXT_PTR = 8'hF0;
    localparam int VPD_FLAG_BIT = 31;
    localparam int VPD_ADDR_LSB = 18;
    localparam int PD_WAIT_BIT = 23;
    localparam int CLK_REC_LSB = 0;
    localparam int LANE_NEG_LSB = 5;
    localparam int L1_ENTER_LSB = 16;
    // ==================================================================
    // eeprom window base added to the product data address
    localparam logic [8:0] EE_BASE = 9'h040;
endpackage : ltv_pkg

// ### src/ltv_regs.sv
// link tuning, product data capability and extended access index registers
`timescale 1ns/100ps
// ======================================================================
// Summary of operation
// - writing flag low starts eeprom read; flag rises when done
// - writing flag high starts eeprom write; flag falls when done
// - data word maps to eeprom at address plus 40h, low byte first
// - data word writes honour configuration byte enables; reads return all four bytes
// - clock recovery field counts training sets, resets to 54h
// - power down wait bit resets set and is driven to power logic
// - capability identifier reads fixed 03h in low byte
// - next pointer reads fixed F0h in bits 15:8
// - tuning register zero enables in bits 4:0 reset to zero
// - lane negotiation tries field bits 7:5 resets to 3h
// - L1 entry timer default bits 31:16 resets to 0400h
// - exit latency fields 22:16 and 14:8 reset to 19h and 2h
// - data window access is redirected to register at held index
module ltv_regs (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    output logic ee_req_o,
    output logic ee_we_o,
    output logic [8:0] ee_addr_o,
    output logic [31:0] ee_wdata_o,
    input wire logic ee_ack_i,
    input wire logic [31:0] ee_rdata_i,
    output logic ext_rd_o,
    output logic ext_wr_o,
    output logic [11:0] ext_addr_o,
    output logic [3:0] ext_be_o,
    output logic [31:0] ext_wdata_o,
    input wire logic ext_ack_i,
    input wire logic [31:0] ext_rdata_i,
    output logic [31:0] tune0_o,
    output logic [31:0] timers_o,
    output logic [31:0] tune2_o
);
    // ==================================================================
    // types and state
    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_EXT = 1'b1
    } ltv_acc_t;
    typedef enum logic [0:0] {
        EE_IDLE = 1'b0,
        EE_BUSY = 1'b1
    } ltv_ee_t;

    ltv_acc_t acc_st_r;
    ltv_ee_t ee_st_r;
    logic [31:0] vpd_data_r;
    logic [11:0] ext_idx_r;
    logic [5:0] vpd_addr_r;
    logic vpd_flag_r;

    // ==================================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be,
                                          input logic [31:0] wmask);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = res & wmask;
    endfunction : merge

    function automatic logic is_local(input logic [11:0] a);
        is_local = (a >= ltv_pkg::TUNE0_OFS) && (a <= ltv_pkg::EXT_DATA_OFS);
    endfunction : is_local

    // ==================================================================
    // access decode
    logic [11:0] req_addr;
    logic [11:0] eff_addr;
    logic take;
    logic loc;
    logic loc_wr;
    logic ee_done;
    logic [31:0] cap_word;
    logic [31:0] rd_val;

    assign req_addr = {cfg_addr_i[11:2], 2'b00};
    assign eff_addr = (req_addr == ltv_pkg::EXT_DATA_OFS) ?
                      {ext_idx_r[11:2], 2'b00} : req_addr;
    assign take = (cfg_rd_i | cfg_wr_i) && (acc_st_r == ACC_IDLE);
    assign loc = is_local(eff_addr);
    assign loc_wr = take && cfg_wr_i && loc;
    assign ee_done = (ee_st_r == EE_BUSY) && ee_ack_i;
    assign cap_word = {vpd_flag_r, 7'h00, vpd_addr_r, 2'b00,
        ltv_pkg::VPD_NEXT_PTR, ltv_pkg::VPD_CAP_ID};

    always_comb begin
        case (eff_addr)
            ltv_pkg::TUNE0_OFS: rd_val = tune0_o;
            ltv_pkg::TIMERS_OFS: rd_val = timers_o;
            ltv_pkg::TUNE2_OFS: rd_val = tune2_o;
            ltv_pkg::VPD_CAP_OFS: rd_val = cap_word;
            ltv_pkg::VPD_DATA_OFS: rd_val = vpd_data_r;
            ltv_pkg::EXT_IDX_OFS: rd_val = {20'h00000, ext_idx_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ==================================================================
    // access sequencer and forwarding of accesses outside the local register range
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            acc_st_r <= ACC_IDLE;
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
            ext_rd_o <= 1'b0;
            ext_wr_o <= 1'b0;
            ext_addr_o <= 12'h000;
            ext_be_o <= 4'h0;
            ext_wdata_o <= 32'h0000_0000;
        end else begin
            cfg_ack_o <= 1'b0;
            ext_rd_o <= 1'b0;
            ext_wr_o <= 1'b0;
            case (acc_st_r)
                ACC_IDLE: begin
                    if (take && loc) begin
                        cfg_ack_o <= 1'b1;
                        cfg_rdata_o <= cfg_rd_i ? rd_val : 32'h0000_0000;
                    end else if (take) begin
                        ext_rd_o <= cfg_rd_i;
                        ext_wr_o <= cfg_wr_i;
                        ext_addr_o <= eff_addr;
                        ext_be_o <= cfg_be_i;
                        ext_wdata_o <= cfg_wdata_i;
                        acc_st_r <= ACC_EXT;
                    end
                end
                ACC_EXT: begin
                    if (ext_ack_i) begin
                        cfg_ack_o <= 1'b1;
                        cfg_rdata_o <= ext_rdata_i;
                        acc_st_r <= ACC_IDLE;
                    end
                end
                default: acc_st_r <= ACC_IDLE;
            endcase
        end
    end

    // ==================================================================
    // link tuning registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tune0_o <= ltv_pkg::TUNE0_RST;
            timers_o <= ltv_pkg::TIMERS_RST;
            tune2_o <= ltv_pkg::TUNE2_RST;
        end else if (loc_wr) begin
            if (eff_addr == ltv_pkg::TUNE0_OFS) begin
                tune0_o <= merge(tune0_o, cfg_wdata_i, cfg_be_i,
                                 ltv_pkg::TUNE0_WMASK);
            end
            if (eff_addr == ltv_pkg::TIMERS_OFS) begin
                timers_o <= merge(timers_o, cfg_wdata_i, cfg_be_i,
                                  ltv_pkg::TIMERS_WMASK);
            end
            if (eff_addr == ltv_pkg::TUNE2_OFS) begin
                tune2_o <= merge(tune2_o, cfg_wdata_i, cfg_be_i,
                    ltv_pkg::TUNE2_WMASK);
            end
        end
    end

    // ==================================================================
    // extended access index
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ext_idx_r <= ltv_pkg::EXT_IDX_RST;
        end else if (loc_wr && eff_addr == ltv_pkg::EXT_IDX_OFS) begin
            ext_idx_r <= 12'(merge({20'h00000, ext_idx_r}, cfg_wdata_i,
                                   cfg_be_i, ltv_pkg::EXT_IDX_WMASK));
        end
    end

    // ==================================================================
    // product data control and eeprom sequencer
    logic vpd_start;
    assign vpd_start = loc_wr && (eff_addr == ltv_pkg::VPD_CAP_OFS) &&
                       cfg_be_i[3] && (ee_st_r == EE_IDLE);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ee_st_r <= EE_IDLE;
            vpd_flag_r <= ltv_pkg::VPD_FLAG_RST;
            vpd_addr_r <= ltv_pkg::VPD_ADDR_RST;
            ee_req_o <= 1'b0;
            ee_we_o <= 1'b0;
            ee_addr_o <= 9'h000;
            ee_wdata_o <= 32'h0000_0000;
        end else begin
            case (ee_st_r)
                EE_IDLE: begin
                    if (loc_wr && eff_addr == ltv_pkg::VPD_CAP_OFS &&
                        cfg_be_i[2]) begin
                        vpd_addr_r <= cfg_wdata_i[ltv_pkg::VPD_ADDR_LSB +: 6];
                    end
                    if (vpd_start) begin
                        vpd_flag_r <=
                            cfg_wdata_i[ltv_pkg::VPD_FLAG_BIT];
                        ee_we_o <= cfg_wdata_i[ltv_pkg::VPD_FLAG_BIT];
                        ee_req_o <= 1'b1;
                        ee_addr_o <= ltv_pkg::EE_BASE + {1'b0,
                            (cfg_be_i[2] ?
                             cfg_wdata_i[ltv_pkg::VPD_ADDR_LSB +: 6] :
                             vpd_addr_r), 2'b00};
                        ee_wdata_o <= vpd_data_r;
                        ee_st_r <= EE_BUSY;
                    end
                end
                EE_BUSY: begin
                    if (ee_ack_i) begin
                        vpd_flag_r <= ~ee_we_o;
                        ee_req_o <= 1'b0;
                        ee_st_r <= EE_IDLE;
                    end
                end
                default: ee_st_r <= EE_IDLE;
            endcase
        end
    end

    // ==================================================================
    // product data word
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            vpd_data_r <= ltv_pkg::VPD_DATA_RST;
        end else if (ee_done && !ee_we_o) begin
            vpd_data_r <= ee_rdata_i;
        end else if (loc_wr && eff_addr == ltv_pkg::VPD_DATA_OFS) begin
            vpd_data_r <= merge(vpd_data_r, cfg_wdata_i, cfg_be_i,
                                32'hFFFF_FFFF);
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    vpd_read_done_a: assert property (
        ee_done && !ee_we_o |=> vpd_flag_r)
        else $error("flag not set after eeprom read");
    vpd_write_done_a: assert property (
        ee_done && ee_we_o |=> !vpd_flag_r)
        else $error("flag not cleared after eeprom write");
    vpd_flag_hold_a: assert property ((ee_st_r == EE_BUSY) && !ee_ack_i
        |=> $stable(vpd_flag_r) && ee_req_o)
        else $error("flag moved while eeprom cycle pending");
    ee_addr_map_a: assert property (ee_req_o |->
        ee_addr_o == ltv_pkg::EE_BASE + {1'b0, vpd_addr_r, 2'b00})
        else $error("eeprom address not offset from product address");
    rd_data_load_a: assert property (ee_done && !ee_we_o
        |=> vpd_data_r == $past(ee_rdata_i))
        else $error("eeprom read data not captured");
    be_partial_wr_a: assert property (loc_wr && !ee_done &&
        eff_addr == ltv_pkg::VPD_DATA_OFS && !cfg_be_i[0]
        |=> vpd_data_r[7:0] == $past(vpd_data_r[7:0]))
        else $error("unselected byte was written");
    cap_header_a: assert property (take && loc && cfg_rd_i &&
        eff_addr == ltv_pkg::VPD_CAP_OFS
        |=> cfg_ack_o && cfg_rdata_o[15:0] == 16'hF003 &&
        cfg_rdata_o[30:24] == 7'h00 && cfg_rdata_o[17:16] == 2'b00)
        else $error("capability header wrong");
    reserved_zero_a: assert property (tune2_o[31:24] == 8'h00)
        else $error("reserved bits not zero");
    ext_redirect_a: assert property (take && !loc &&
        req_addr == ltv_pkg::EXT_DATA_OFS
        |=> (ext_rd_o || ext_wr_o) &&
        ext_addr_o == {ext_idx_r[11:2], 2'b00})
        else $error("window access not redirected to index");
    op_dir_match_a: assert property ($rose(ee_req_o) |->
        ee_we_o == vpd_flag_r)
        else $error("operation direction differs from flag");
    pd_wait_rst_a: assert property ($fell(rst_i) |->
        tune2_o[ltv_pkg::PD_WAIT_BIT])
        else $error("power down wait not set after reset");

    vpd_read_c: cover property (ee_done && !ee_we_o);
    vpd_write_c: cover property (ee_done && ee_we_o);
    ext_access_c: cover property ((acc_st_r == ACC_EXT) && ext_ack_i);
endmodule : ltv_regs
